// ===== common/slope_cal_pkg.sv
// Constants and carrier types for the slope calibration unit
// Summary of operation
// - Sample selected switch node with four comparators
// - Cycle covers rising and falling slope
// - Control write arms with new settings
// - Channel select binary names half-bridge directly
// - Four-bit precharge and delay instants, both slopes
// - Select 000 disables unit, reset default
// - Sampling starts at next routed edge
// - Done after rising and falling; store results
// - Ready reads zero until done, clears on read
// - Ready set only when both slopes valid
// - Slope calibration repeats until done, then holds until next control write
// - Rising precharge code from three thresholds
// - Rising delay code from three thresholds
// - Falling precharge code from three thresholds
// - Falling delay code from three thresholds
// - Ready bit 8, rise codes above fall
package slope_cal_pkg;
    localparam int NUM_CHANNELS = 6;
    localparam int SEL_W        = 3;
    localparam int TSEL_W       = 4;
    localparam int CTRL_W       = 11;
    localparam int RESULT_W     = 12;
    localparam int CMP_W        = 4;
    localparam int TICK_W       = 8;
    // Comparator thresholds, ascending: 5%, 15%, 85%, 95%
    localparam int CMP_5  = 0;
    localparam int CMP_15 = 1;
    localparam int CMP_85 = 2;
    localparam int CMP_95 = 3;
    localparam logic [SEL_W-1:0] SEL_OFF = 3'h0;
    localparam logic [TICK_W-1:0] TICKS_PER_STEP = 8'h04;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
    localparam logic [1:0] CODE_0 = 2'h0;
    localparam logic [1:0] CODE_1 = 2'h1;
    localparam logic [1:0] CODE_2 = 2'h2;
    localparam logic [1:0] CODE_3 = 2'h3;
    // Control register layout: delay[10:7] precharge[6:3] select[2:0]
    typedef struct packed {
        logic [TSEL_W-1:0] delay_sample_time_sel;
        logic [TSEL_W-1:0] precharge_sample_time_sel;
        logic [SEL_W-1:0]  channel_sel;
    } slope_cal_control_t;
    // Result register layout
    typedef struct packed {
        logic [2:0] zero_top;
        logic       ready;
        logic [1:0] rise_delay_code;
        logic [1:0] rise_precharge_code;
        logic [1:0] fall_delay_code;
        logic [1:0] fall_precharge_code;
    } slope_cal_result_t;
    typedef enum logic [0:0] {SLOPE_RISE, SLOPE_FALL} slope_t;
endpackage

// ===== hdl/slope_sample_timer.sv
// Sample instant timer: pulses at precharge and delay instants after a start
module slope_sample_timer
#(
    parameter int TSEL_W = slope_cal_pkg::TSEL_W,
    parameter int TICK_W = slope_cal_pkg::TICK_W
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              start,
    input  wire logic              abort,
    input  wire logic [TSEL_W-1:0] pc_sel,
    input  wire logic [TSEL_W-1:0] dly_sel,
    output logic                   pc_hit,
    output logic                   dly_hit
);
    logic [TICK_W-1:0] prescale;
    logic [TSEL_W:0]   steps;
    logic              running;
    logic              step_en;

    assign step_en = running && (prescale == slope_cal_pkg::TICKS_PER_STEP - 8'h01);

    // Step prescaler gives one enable per sample-time step
    always_ff @(posedge clk)
    begin
        if (reset || start || abort || step_en)
            prescale <= '0;
        else if (running)
            prescale <= prescale + 8'h01;
    end

    // Steps count; precharge instant first, delay instant after it
    always_ff @(posedge clk)
    begin
        pc_hit  <= 1'b0;
        dly_hit <= 1'b0;
        if (reset || abort)
        begin
            running <= 1'b0;
            steps   <= '0;
        end
        else if (start)
        begin
            running <= 1'b1;
            steps   <= '0;
        end
        else if (step_en)
        begin
            steps <= steps + 5'h01;
            if (steps == {1'b0, pc_sel})
                pc_hit <= 1'b1;
            if (steps == {1'b0, pc_sel} + {1'b0, dly_sel} + 5'h01)
            begin
                dly_hit <= 1'b1;
                running <= 1'b0;
            end
        end
    end
endmodule

// ===== hdl/slope_calibration_unit.sv
// Slope calibration unit: arms, samples switch node, encodes and reports results
module slope_calibration_unit
#(
    parameter int NUM_CHANNELS = slope_cal_pkg::NUM_CHANNELS,
    parameter int CMP_W        = slope_cal_pkg::CMP_W
)
(
    input  wire logic                                      clk,
    input  wire logic                                      reset,
    input  wire logic                                      control_write,
    input  wire logic [slope_cal_pkg::CTRL_W-1:0]          control_wdata,
    input  wire logic                                      result_read,
    input  wire logic [NUM_CHANNELS-1:0]                   pulse_width_input,
    input  wire logic [NUM_CHANNELS-1:0][CMP_W-1:0]        switch_node_cmp,
    output slope_cal_pkg::slope_cal_control_t              slope_cal_control,
    output slope_cal_pkg::slope_cal_result_t               slope_cal_result,
    output logic [NUM_CHANNELS-1:0]                        cmp_mux_sel
);
    typedef enum logic [2:0] {IDLE, WAIT_EDGE, SAMPLE, DONE} cal_state_t;

    cal_state_t        state;
    cal_state_t        next_state;
    logic [NUM_CHANNELS-1:0] pwm_prev;
    logic [NUM_CHANNELS-1:0] edge_hits;
    logic              sel_edge;
    logic              sel_level;
    logic              sel_valid;
    logic [CMP_W-1:0]  cmp_now;
    logic              slope_rise;
    logic              rise_done;
    logic              fall_done;
    logic              pc_hit;
    logic              dly_hit;
    logic              timer_start;
    logic              abort;
    logic [1:0]        rise_pc;
    logic [1:0]        rise_dly;
    logic [1:0]        fall_pc;
    logic [1:0]        fall_dly;
    logic              pc_seen;
    logic [CMP_W-1:0]  cmp_pc;
    logic              slope_end;
    logic              slope_ok;
    logic              cal_complete;
    logic [1:0]        new_pc_code;
    logic [1:0]        new_dly_code;

    // Thermometer level to rising precharge code
    function automatic logic [1:0] code_rise_pc(input logic [CMP_W-1:0] c);
        if (c[slope_cal_pkg::CMP_85])
            return slope_cal_pkg::CODE_3;
        else if (c[slope_cal_pkg::CMP_15])
            return slope_cal_pkg::CODE_2;
        else if (c[slope_cal_pkg::CMP_5])
            return slope_cal_pkg::CODE_1;
        return slope_cal_pkg::CODE_0;
    endfunction

    // Thermometer level to rising delay code
    function automatic logic [1:0] code_rise_dly(input logic [CMP_W-1:0] c);
        if (c[slope_cal_pkg::CMP_95])
            return slope_cal_pkg::CODE_3;
        else if (c[slope_cal_pkg::CMP_85])
            return slope_cal_pkg::CODE_2;
        else if (c[slope_cal_pkg::CMP_15])
            return slope_cal_pkg::CODE_1;
        return slope_cal_pkg::CODE_0;
    endfunction

    // Thermometer level to falling precharge code
    function automatic logic [1:0] code_fall_pc(input logic [CMP_W-1:0] c);
        if (!c[slope_cal_pkg::CMP_15])
            return slope_cal_pkg::CODE_3;
        else if (!c[slope_cal_pkg::CMP_85])
            return slope_cal_pkg::CODE_2;
        else if (!c[slope_cal_pkg::CMP_95])
            return slope_cal_pkg::CODE_1;
        return slope_cal_pkg::CODE_0;
    endfunction

    // Thermometer level to falling delay code
    function automatic logic [1:0] code_fall_dly(input logic [CMP_W-1:0] c);
        if (!c[slope_cal_pkg::CMP_5])
            return slope_cal_pkg::CODE_3;
        else if (!c[slope_cal_pkg::CMP_15])
            return slope_cal_pkg::CODE_2;
        else if (!c[slope_cal_pkg::CMP_85])
            return slope_cal_pkg::CODE_1;
        return slope_cal_pkg::CODE_0;
    endfunction

    // Comparator outputs are clean thresholds; valid only if monotonic
    function automatic logic cmp_ok(input logic [CMP_W-1:0] c);
        logic ok;
        ok = 1'b1;
        for (int i = 1; i < CMP_W; i++)
            if (c[i] && !c[i-1])
                ok = 1'b0;
        return ok;
    endfunction

    // Per-channel edge detect on the routed PWM inputs
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++)
        begin : g_edge
            assign edge_hits[ch] = pulse_width_input[ch] ^ pwm_prev[ch];
        end
    endgenerate

    // Channel n maps to input index n-1; zero and out-of-range are off
    assign sel_valid = (slope_cal_control.channel_sel != slope_cal_pkg::SEL_OFF) &&
                       (32'(slope_cal_control.channel_sel) <= NUM_CHANNELS);
    assign sel_edge  = sel_valid && edge_hits[slope_cal_control.channel_sel - 3'h1];
    assign sel_level = sel_valid && pulse_width_input[slope_cal_control.channel_sel - 3'h1];
    assign cmp_now   = sel_valid ? switch_node_cmp[slope_cal_control.channel_sel - 3'h1]
                                 : '0;
    assign abort     = control_write;
    assign timer_start = (state != DONE) && sel_edge && !control_write;

    // Slope outcome; a cycle completes only on clean samples of the last slope
    assign slope_end    = (state == SAMPLE) && dly_hit && !timer_start && !control_write;
    assign slope_ok     = pc_seen && cmp_ok(cmp_pc) && cmp_ok(cmp_now);
    assign cal_complete = slope_end && slope_ok && (slope_rise ? fall_done : rise_done);

    // Remember last PWM levels
    always_ff @(posedge clk)
    begin
        if (reset)
            pwm_prev <= '0;
        else
            pwm_prev <= pulse_width_input;
    end

    // Control register; reset leaves the unit off
    always_ff @(posedge clk)
    begin
        if (reset)
            slope_cal_control <= slope_cal_pkg::CTRL_RESET;
        else if (control_write)
            slope_cal_control <= control_wdata;
    end

    // Comparator mux select drive, one-hot to the analog multiplexer
    always_ff @(posedge clk)
    begin
        if (reset)
            cmp_mux_sel <= '0;
        else
        begin
            cmp_mux_sel <= '0;
            if (sel_valid)
                cmp_mux_sel[slope_cal_control.channel_sel - 3'h1] <= 1'b1;
        end
    end

    slope_sample_timer u_timer
    (
        .clk     (clk),
        .reset   (reset),
        .start   (timer_start),
        .abort   (abort),
        .pc_sel  (slope_cal_control.precharge_sample_time_sel),
        .dly_sel (slope_cal_control.delay_sample_time_sel),
        .pc_hit  (pc_hit),
        .dly_hit (dly_hit)
    );

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            IDLE:
            begin
                if (timer_start)
                    next_state = SAMPLE;
                else if (sel_valid)
                    next_state = WAIT_EDGE;
            end
            WAIT_EDGE:
            begin
                if (timer_start)
                    next_state = SAMPLE;
            end
            SAMPLE:
            begin
                if (timer_start)
                    next_state = SAMPLE;
                else if (cal_complete)
                    next_state = DONE;
                else if (dly_hit)
                    next_state = WAIT_EDGE;
            end
            DONE:      next_state = DONE;
            default:   next_state = IDLE;
        endcase
        if (control_write)
            next_state = IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state <= IDLE;
        else
            state <= next_state;
    end

    // Slope direction latched from the PWM level at the edge
    always_ff @(posedge clk)
    begin
        if (reset)
            slope_rise <= 1'b0;
        else if (timer_start)
            slope_rise <= sel_level;
    end

    // Precharge instant reached for the slope in flight
    always_ff @(posedge clk)
    begin
        if (reset || control_write || timer_start)
            pc_seen <= 1'b0;
        else if (pc_hit)
            pc_seen <= 1'b1;
    end

    // Comparator states held from the precharge instant
    always_ff @(posedge clk)
    begin
        if (reset || control_write || timer_start)
            cmp_pc <= '0;
        else if (pc_hit)
            cmp_pc <= cmp_now;
    end

    // Codes of the slope in flight, by its direction
    always_comb
    begin
        if (slope_rise)
        begin
            new_pc_code  = code_rise_pc(cmp_pc);
            new_dly_code = code_rise_dly(cmp_now);
        end
        else
        begin
            new_pc_code  = code_fall_pc(cmp_pc);
            new_dly_code = code_fall_dly(cmp_now);
        end
    end

    // Rising slope done; a bad comparator pattern leaves it pending for repeat
    always_ff @(posedge clk)
    begin
        if (reset || control_write)
            rise_done <= 1'b0;
        else if (slope_end && slope_ok && slope_rise)
            rise_done <= 1'b1;
    end

    // Falling slope done, same rule as the rising one
    always_ff @(posedge clk)
    begin
        if (reset || control_write)
            fall_done <= 1'b0;
        else if (slope_end && slope_ok && !slope_rise)
            fall_done <= 1'b1;
    end

    // Rising slope codes kept until the falling slope completes
    always_ff @(posedge clk)
    begin
        if (reset || control_write)
        begin
            rise_pc  <= '0;
            rise_dly <= '0;
        end
        else if (slope_end && slope_ok && slope_rise)
        begin
            rise_pc  <= new_pc_code;
            rise_dly <= new_dly_code;
        end
    end

    // Falling slope codes kept until the rising slope completes
    always_ff @(posedge clk)
    begin
        if (reset || control_write)
        begin
            fall_pc  <= '0;
            fall_dly <= '0;
        end
        else if (slope_end && slope_ok && !slope_rise)
        begin
            fall_pc  <= new_pc_code;
            fall_dly <= new_dly_code;
        end
    end

    // Result register and ready flag; completion wins over read-clear
    always_ff @(posedge clk)
    begin
        if (reset)
            slope_cal_result <= '0;
        else
        begin
            slope_cal_result.zero_top <= '0;
            if (state == SAMPLE && next_state == DONE)
            begin
                slope_cal_result.ready               <= 1'b1;
                slope_cal_result.rise_delay_code     <= slope_rise ? code_rise_dly(cmp_now)
                                                                   : rise_dly;
                slope_cal_result.rise_precharge_code <= slope_rise ? code_rise_pc(cmp_pc)
                                                                   : rise_pc;
                slope_cal_result.fall_delay_code     <= slope_rise ? fall_dly
                                                                   : code_fall_dly(cmp_now);
                slope_cal_result.fall_precharge_code <= slope_rise ? fall_pc
                                                                   : code_fall_pc(cmp_pc);
            end
            else if (result_read)
                slope_cal_result.ready <= 1'b0;
        end
    end
endmodule

// ===== bench/sn_model.sv
// Switch-node comparator model standing beside the calibration unit
module sn_model
(
    input  wire logic            clk,
    input  wire logic [5:0]      pwm,
    input  wire logic [3:0][2:0] lv,
    output logic      [5:0][3:0] cmp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] prev = 6'h00;
    logic [7:0] age  = 8'h00;
    logic [2:0] ch   = 3'h0;
    logic [2:0] n;
    // Track the node that switched last and the time since its edge
    always_ff @(posedge clk)
    begin
        prev <= pwm;
        age  <= (pwm != prev) ? 8'h00 : age + {7'h00, age != 8'hff};
        for (int i = 0; i < 6; i++)
            if (pwm[i] != prev[i])
                ch <= 3'(i);
    end
    // Thermometer levels on the active node, changing junk on the others
    always_comb
    begin
        n = lv[{~pwm[ch], age > 8'h0c}];
        for (int i = 0; i < 6; i++)
            cmp[i] = {4{age[0]}} ^ 4'ha;
        cmp[ch] = (n > 3'h4) ? 4'ha : 4'((5'h01 << n) - 5'h01);  // broken pattern
    end
endmodule

// ===== bench/slope_calibration_unit_chk.sv
// Port checker for the slope calibration unit
module slope_calibration_unit_chk
#(
    parameter int NUM_CHANNELS = slope_cal_pkg::NUM_CHANNELS,
    parameter int CMP_W        = slope_cal_pkg::CMP_W
)
(
    input wire logic                                clk,
    input wire logic                                reset,
    input wire logic                                control_write,
    input wire logic [slope_cal_pkg::CTRL_W-1:0]    control_wdata,
    input wire logic                                result_read,
    input wire logic [NUM_CHANNELS-1:0]             pulse_width_input,
    input wire logic [NUM_CHANNELS-1:0][CMP_W-1:0]  switch_node_cmp,
    input wire slope_cal_pkg::slope_cal_control_t   slope_cal_control,
    input wire slope_cal_pkg::slope_cal_result_t    slope_cal_result,
    input wire logic [NUM_CHANNELS-1:0]             cmp_mux_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NUM_CHANNELS-1:0] dec;
    logic [NUM_CHANNELS-1:0] pwm_q;
    logic [7:0]              quiet;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // Expected one-hot comparator selection
    always_comb
        dec = (slope_cal_control.channel_sel inside {[1:NUM_CHANNELS]}) ?
              NUM_CHANNELS'(1) << (slope_cal_control.channel_sel - 3'h1) : '0;
    // Cycles since the last pulse edge on any channel
    always_ff @(posedge clk)
    begin
        pwm_q <= pulse_width_input;
        if (reset || pulse_width_input != pwm_q)
            quiet <= 8'h00;
        else if (quiet != 8'hff)
            quiet <= quiet + 8'h01;
    end
    property p_ctrl_load;
        control_write |=> slope_cal_control == $past(control_wdata);
    endproperty
    a_ctrl_load: assert property (p_ctrl_load)
        else $error("control load wrong");
    property p_zero_top;
        slope_cal_result.zero_top == 3'h0;
    endproperty
    a_zero_top: assert property (p_zero_top)
        else $error("result top bits not zero");
    property p_mux_sel;
        $stable(slope_cal_control) [*2] |-> cmp_mux_sel == dec;
    endproperty
    a_mux_sel: assert property (p_mux_sel)
        else $error("comparator selection wrong");
    property p_rise_armed;
        $rose(slope_cal_result.ready) |-> $past(slope_cal_control.channel_sel) != 3'h0;
    endproperty
    a_rise_armed: assert property (p_rise_armed)
        else $error("ready while unit off");
    property p_read_clears;
        slope_cal_result.ready && result_read && !control_write |=> ##1 !slope_cal_result.ready;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("ready not cleared by read");
    property p_ready_hold;
        slope_cal_result.ready && !result_read && !$past(result_read) && !control_write
            && !$past(control_write) |=> slope_cal_result.ready;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("ready dropped");
    property p_codes_hold;
        $past(slope_cal_result.ready) && slope_cal_result.ready |-> $stable(slope_cal_result);
    endproperty
    a_codes_hold: assert property (p_codes_hold)
        else $error("result changed while ready");
    property p_ready_after_edge;
        $rose(slope_cal_result.ready) |-> quiet <= 8'h96;
    endproperty
    a_ready_after_edge: assert property (p_ready_after_edge)
        else $error("ready without recent edge");
    c_done: cover property ($rose(slope_cal_result.ready));
    c_read: cover property (slope_cal_result.ready && result_read);
    c_abort: cover property (control_write && control_wdata[2:0] == 3'h0);
endmodule

bind slope_calibration_unit slope_calibration_unit_chk #(.NUM_CHANNELS(NUM_CHANNELS),
    .CMP_W(CMP_W)) u_chk (.clk(clk), .reset(reset), .control_write(control_write),
    .control_wdata(control_wdata), .result_read(result_read),
    .pulse_width_input(pulse_width_input), .switch_node_cmp(switch_node_cmp),
    .slope_cal_control(slope_cal_control), .slope_cal_result(slope_cal_result),
    .cmp_mux_sel(cmp_mux_sel));

// ===== bench/tb_top.sv
// Self-checking bench for the slope calibration unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0][9:0] TBL = {10'h01b, 10'h06f, 10'h390, 10'h3e4};
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    logic            ctrl_wr = 1'b0;
    logic [10:0]     ctrl_data = 11'h000;
    logic            res_rd = 1'b0;
    logic [5:0]      pwm = 6'h00;
    logic [3:0][2:0] lv = 12'h000;
    logic [5:0][3:0] cmp;
    logic [10:0]     ctrl;
    logic [11:0]     res;
    logic [5:0]      mux;
    int              n_errors = 0;
    int              samples_checked = 0;
    // Free-running clock
    always #5 clk = ~clk;
    slope_calibration_unit DUT (.clk(clk), .reset(reset), .control_write(ctrl_wr),
        .control_wdata(ctrl_data), .result_read(res_rd), .pulse_width_input(pwm),
        .switch_node_cmp(cmp), .slope_cal_control(ctrl), .slope_cal_result(res),
        .cmp_mux_sel(mux));
    sn_model u_sn (.clk(clk), .pwm(pwm), .lv(lv), .cmp(cmp));
    task close_out;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [10:0] d);
        @(posedge clk);
        ctrl_wr   <= 1'b1;
        ctrl_data <= d;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        #1;
    endtask
    task rd;
        @(posedge clk);
        res_rd <= 1'b1;
        @(posedge clk);
        res_rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task edge_on(input int c, input logic v, input int n);
        @(posedge clk);
        pwm[c-1] <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Full rise and fall calibration on one channel, levels vary per channel
    task run_ch(input int c);
        logic [11:0] exp;
        exp = {4'h1, TBL[1][(c+1)%5*2+:2], TBL[0][(c-1)%5*2+:2],
               TBL[3][(c+3)%5*2+:2], TBL[2][(c+2)%5*2+:2]};
        @(posedge clk);
        lv <= {3'((c+3)%5), 3'((c+2)%5), 3'((c+1)%5), 3'((c-1)%5)};
        wr({4'h3, 4'h0, 3'(c)});
        chk("control", {1'b0, 4'h3, 4'h0, 3'(c)}, {1'b0, ctrl});
        edge_on(c, 1'b1, 40);
        chk("mux", 12'(1 << (c - 1)), {6'h00, mux});
        chk("early ready", 12'h000, {11'h000, res[8]});
        edge_on(c, 1'b0, 0);
        for (int i = 0; i < 100 && res[8] !== 1'b1; i++)
            @(posedge clk);
        #1;
        chk("result", exp, res);
        rd;
        chk("ready after read", 12'h000, {11'h000, res[8]});
        $display("test channel %0d done", c);
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset result", 12'h000, res);
        chk("reset control", 12'h000, {1'b0, ctrl});
        $display("test reset done");
        for (int c = 1; c <= 6; c++)
            run_ch(c);
        wr(11'h182);
        edge_on(2, 1'b1, 40);
        wr(11'h000);
        edge_on(2, 1'b0, 60);
        chk("abort ready", 12'h000, {11'h000, res[8]});
        chk("abort mux", 12'h000, {6'h00, mux});
        $display("test abort done");
        run_ch(2);
        // Lone falling slope on channel 2 must not carry into channel 5
        edge_on(2, 1'b1, 2);
        wr(11'h182);
        edge_on(2, 1'b0, 40);
        run_ch(5);
        // Broken comparator pattern on the falling slope, then a clean repeat
        @(posedge clk);
        lv <= {3'h2, 3'h7, 3'h3, 3'h1};
        wr(11'h183);
        edge_on(3, 1'b1, 40);
        edge_on(3, 1'b0, 60);
        chk("bad sample ready", 12'h000, {11'h000, res[8]});
        @(posedge clk);
        lv <= {3'h2, 3'h2, 3'h3, 3'h1};
        edge_on(3, 1'b1, 40);
        edge_on(3, 1'b0, 60);
        chk("retry result", 12'h196, res);
        rd;
        $display("test bad sample done");
        close_out;
    end
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        close_out;
    end
endmodule
